// ===== hw/sfhi_pkg.sv
// Constants, opcodes and types of the serial flash front end
// *********************************************************
package sfhi_pkg;
  localparam int CLK_MHZ = 40;
  localparam int RST_REC_NS = 30000;
  localparam int RST_REC_CYC = (RST_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_W = 11;
  localparam logic [BUSY_W-1:0] BSY_LOAD = BUSY_W'(RST_REC_CYC);
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;

  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FRD = 8'h0B;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIOR = 8'hBB;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QIOR = 8'hEB;
  localparam logic [7:0] OP_DTRRD = 8'h0D;
  localparam logic [7:0] OP_RD4 = 8'h13;
  localparam logic [7:0] OP_FRD4 = 8'h0C;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_PP4 = 8'h12;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_SE4 = 8'h21;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_QPI_ON = 8'h38;
  localparam logic [7:0] OP_QPI_OFF = 8'hFF;
  localparam logic [7:0] OP_A4_ON = 8'hB7;
  localparam logic [7:0] OP_A4_OFF = 8'hE9;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;

  localparam logic [3:0] DMY_FAST = 4'h8;
  localparam logic [3:0] DMY_DIO = 4'h4;
  localparam logic [3:0] DMY_QIO = 4'h6;
  localparam logic [3:0] DMY_DTR = 4'h8;
  localparam logic [2:0] L1 = 3'h1;
  localparam logic [2:0] L2 = 3'h2;
  localparam logic [2:0] L4 = 3'h4;
  localparam logic [5:0] ABITS3 = 6'h18;
  localparam logic [5:0] ABITS4 = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [3:0] TX_BITS = 4'h8;
  localparam int SR_ADS = 0;
  localparam int SR_ADP = 1;
  localparam logic [5:0] SYNC_RST = 6'h20;
  localparam logic A4_RST = 1'b0;
  localparam logic QPI_RST = 1'b0;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_DMY = 7'h08,
    ST_RDAT = 7'h10,
    ST_WDAT = 7'h20,
    ST_IGN = 7'h40
  } sfhi_st_t;

  typedef struct packed {
    logic ok;
    logic adr;
    logic f4;
    logic rd;
    logic wr;
    logic qd;
    logic dtr;
    logic st;
    logic [2:0] al;
    logic [2:0] dl;
    logic [3:0] dmy;
  } sfhi_cmd_t;
endpackage : sfhi_pkg

// ===== hw/sfhi_fifo.sv
// Write-data FIFO with a registered read stage
`timescale 1ns/100ps
module sfhi_fifo
  import sfhi_pkg::*;
#(
  parameter int W = FIFO_W, // Word width
  parameter int D = FIFO_D // Depth, a power of two
) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word present
  input wire logic out_ready, // Reader takes word
  output logic [W-1:0] out_data // Word out
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW + 1)'(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic ov_r, ov_nxt, wr, rd;
  logic [W-1:0] od_r, od_nxt;

  always_comb begin
    wr = in_valid && (cnt_r != FULL);
    rd = (cnt_r != '0) && (!ov_r || out_ready);
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW + 1)'(wr) - (AW + 1)'(rd);
    ov_nxt = rd ? 1'b1 : (ov_r && !out_ready);
    od_nxt = rd ? mem_r[rp_r] : od_r;
  end

  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ov_r <= ov_nxt;
      od_r <= od_nxt;
    end
  end

  assign in_ready = (cnt_r != FULL);
  assign out_valid = ov_r;
  assign out_data = od_r;
endmodule : sfhi_fifo

// ===== hw/sfhi_core.sv
// Device-side serial flash front end: pins, modes, pause and reset
`timescale 1ns/100ps
module sfhi_core
  import sfhi_pkg::*;
#(
  parameter int FIFO_WD = FIFO_W, // Write data width
  parameter int FIFO_DP = FIFO_D // Write data depth
) (
  input wire logic clk_sys, // 40 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic serial_clock, // Serial clock pin
  input wire logic chip_select_n, // Chip select pin
  input wire logic [3:0] data_line_in, // data_line_3..0 levels
  output logic [3:0] data_line_out, // data_line_3..0 drive
  output logic [3:0] data_line_oe, // High while driving
  input wire logic quad_enable, // Non-volatile quad enable
  input wire logic powerup_address_width, // 1 selects 4-byte
  input wire logic [7:0] ext_addr, // Extended address byte
  input wire logic [7:0] tx_byte, // Next read byte
  output logic tx_take, // Pulse, tx_byte taken
  output logic [7:0] cmd, // Accepted opcode
  output logic [31:0] addr, // Full address
  output logic cmd_valid, // Pulse, cmd and addr ready
  output logic cmd_end, // Pulse, accepted frame closed
  output logic [7:0] wr_data, // Write byte out
  output logic wr_valid, // Write byte present
  input wire logic wr_ready, // Write byte taken
  output logic wr_overrun, // Write byte lost
  output logic four_line_instruction_mode, // Mode flag
  output logic current_address_width, // 1 means 4-byte
  output logic paused, // Pause active
  output logic busy // Reset recovery
);

  // *********************************************************
  // Pin synchronisers and edges
  // *********************************************************
  logic [5:0] s1_r, s2_r;
  logic sck_p_r, cs_p_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      sck_p_r <= 1'b0;
      cs_p_r <= 1'b1;
    end else begin
      s1_r <= {chip_select_n, serial_clock, data_line_in};
      s2_r <= s1_r;
      sck_p_r <= s2_r[4];
      cs_p_r <= s2_r[5];
    end
  end

  // Both edges seen only while selected, so idle level is irrelevant
  wire cs_hi = s2_r[5];
  wire sck = s2_r[4];
  wire [3:0] din = s2_r[3:0];
  wire rise = sck & ~sck_p_r;
  wire fall = ~sck & sck_p_r;
  wire cs_fall = ~cs_hi & cs_p_r;
  wire cs_rise = cs_hi & ~cs_p_r;

  // *********************************************************
  // Helpers
  // *********************************************************
  function automatic logic [31:0] shin(logic [31:0] v, logic [2:0] n,
                                       logic [3:0] d);
    case (n)
      L4: shin = {v[27:0], d};
      L2: shin = {v[29:0], d[1:0]};
      default: shin = {v[30:0], d[0]};
    endcase
  endfunction : shin

  function automatic logic [3:0] topb(logic [7:0] v, logic [2:0] n);
    case (n)
      L4: topb = v[7:4];
      L2: topb = {2'h0, v[7:6]};
      default: topb = {2'h0, v[7], 1'b0};
    endcase
  endfunction : topb

  function automatic logic [3:0] oem(logic [2:0] n);
    case (n)
      L4: oem = 4'hF;
      L2: oem = 4'h3;
      default: oem = 4'h2;
    endcase
  endfunction : oem

  function automatic sfhi_cmd_t cinfo(logic [7:0] op);
    sfhi_cmd_t c;
    c = '0;
    c.ok = 1'b1;
    c.al = L1;
    c.dl = L1;
    c.adr = 1'b1;
    case (op)
      OP_RD, OP_RD4: c.rd = 1'b1;
      OP_FRD, OP_FRD4: begin
        c.rd = 1'b1;
        c.dmy = DMY_FAST;
      end
      OP_DOR: begin
        c.rd = 1'b1;
        c.dl = L2;
        c.dmy = DMY_FAST;
      end
      OP_DIOR: begin
        c.rd = 1'b1;
        c.al = L2;
        c.dl = L2;
        c.dmy = DMY_DIO;
      end
      OP_QOR: begin
        c.rd = 1'b1;
        c.qd = 1'b1;
        c.dl = L4;
        c.dmy = DMY_FAST;
      end
      OP_QIOR: begin
        c.rd = 1'b1;
        c.qd = 1'b1;
        c.al = L4;
        c.dl = L4;
        c.dmy = DMY_QIO;
      end
      OP_DTRRD: begin
        c.rd = 1'b1;
        c.dtr = 1'b1;
        c.dmy = DMY_DTR;
      end
      OP_PP, OP_PP4: c.wr = 1'b1;
      OP_QPP: begin
        c.wr = 1'b1;
        c.qd = 1'b1;
        c.dl = L4;
      end
      OP_SE, OP_SE4: c.wr = 1'b0;
      OP_RDSR3: begin
        c.adr = 1'b0;
        c.rd = 1'b1;
        c.st = 1'b1;
      end
      OP_QPI_ON, OP_QPI_OFF, OP_A4_ON, OP_A4_OFF, OP_RSTEN, OP_RST: c.adr = 1'b0;
      default: c.ok = 1'b0;
    endcase
    c.f4 = (op == OP_RD4) | (op == OP_FRD4) | (op == OP_PP4) | (op == OP_SE4);
    return c;
  endfunction : cinfo

  // *********************************************************
  // Frame engine
  // *********************************************************
  sfhi_st_t st_r, st_nxt;
  sfhi_cmd_t inf_r, inf_nxt;
  logic [31:0] sh_r, sh_nxt, addr_r, addr_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [7:0] cmd_r, cmd_nxt, tx_r, tx_nxt, pd_r, pd_nxt;
  logic [3:0] txc_r, txc_nxt, dout_r, dout_nxt, oe_r, oe_nxt;
  logic cv_r, cv_nxt, take_r, take_nxt, drv_r, drv_nxt, ok_r, ok_nxt;
  logic qpi_r, qpi_nxt, a4_r, a4_nxt, ren_r, ren_nxt, arm_r, arm_nxt;
  logic pz_r, pz_nxt, init_r, init_nxt, end_r, end_nxt;
  logic push_r, push_nxt, ovf_r, ovf_nxt, bf_r, bf_nxt;
  logic [BUSY_W-1:0] bsy_r, bsy_nxt;
  logic fifo_rdy;

  wire [2:0] al = qpi_r ? L4 : inf_r.al;
  wire [2:0] dl = qpi_r ? L4 : inf_r.dl;
  wire [5:0] alen = (a4_r | inf_r.f4) ? ABITS4 : ABITS3;
  wire hold_ok = ~quad_enable & ~qpi_r;
  wire bsy = |bsy_r;
  // Paused frames see no edges at all
  // The fall right after the last opcode rise still belongs to the opcode
  wire ien = ~pz_r & (rise | (inf_r.dtr & fall & (st_r == ST_ADDR)
                              & (cnt_r != 6'h00)));
  wire oen = ~pz_r & (fall | (inf_r.dtr & rise));

  always_comb begin
    logic load;
    logic [7:0] stat;
    load = 1'b0;
    stat = '0;
    stat[SR_ADS] = a4_r;
    stat[SR_ADP] = powerup_address_width;
    st_nxt = st_r;
    inf_nxt = inf_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    txc_nxt = txc_r;
    dout_nxt = dout_r;
    oe_nxt = 4'h0;
    pd_nxt = pd_r;
    drv_nxt = drv_r;
    ok_nxt = ok_r;
    qpi_nxt = qpi_r;
    a4_nxt = a4_r;
    ren_nxt = ren_r;
    cv_nxt = 1'b0;
    take_nxt = 1'b0;
    end_nxt = 1'b0;
    arm_nxt = arm_r | cs_hi;
    init_nxt = 1'b1;
    bsy_nxt = bsy ? bsy_r - 1'b1 : bsy_r;
    push_nxt = push_r && !fifo_rdy;
    ovf_nxt = cs_fall ? 1'b0 : ovf_r;
    if (!init_r) begin
      a4_nxt = powerup_address_width;
    end
    // Pin level is the request; the change waits for a low clock
    if (cs_hi || !hold_ok) begin
      pz_nxt = 1'b0;
    end else if (!sck && (din[3] == pz_r)) begin
      pz_nxt = ~din[3];
    end else begin
      pz_nxt = pz_r;
    end
    if (cs_rise && ok_r) begin
      end_nxt = 1'b1;
      ren_nxt = (cmd_r == OP_RSTEN);
      case (cmd_r)
        OP_QPI_ON: qpi_nxt = qpi_r | quad_enable;
        OP_QPI_OFF: qpi_nxt = 1'b0;
        OP_A4_ON: a4_nxt = 1'b1;
        OP_A4_OFF: a4_nxt = 1'b0;
        OP_RST: begin
          if (ren_r) begin
            qpi_nxt = QPI_RST;
            a4_nxt = powerup_address_width;
            bsy_nxt = BSY_LOAD;
          end
        end
        default: qpi_nxt = qpi_r;
      endcase
    end
    if (cs_hi) begin
      st_nxt = ST_IDLE;
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (cs_fall) begin
            st_nxt = (arm_r && !bsy) ? ST_CMD : ST_IGN;
            cnt_nxt = '0;
            sh_nxt = '0;
            ok_nxt = 1'b0;
          end
        end
        ST_CMD: begin
          if (ien) begin
            sh_nxt = shin(sh_r, qpi_r ? L4 : L1, din);
            cnt_nxt = cnt_r + 6'(qpi_r ? L4 : L1);
            if (cnt_nxt == BYTE_BITS) begin
              cmd_nxt = sh_nxt[7:0];
              inf_nxt = cinfo(sh_nxt[7:0]);
              cnt_nxt = '0;
              sh_nxt = '0;
              if (!inf_nxt.ok || (inf_nxt.qd && !quad_enable)) begin
                st_nxt = ST_IGN;
              end else begin
                ok_nxt = 1'b1;
                cv_nxt = !inf_nxt.adr;
                if (inf_nxt.adr) begin
                  st_nxt = ST_ADDR;
                end else if (inf_nxt.rd) begin
                  st_nxt = ST_RDAT;
                  load = 1'b1;
                end else begin
                  st_nxt = ST_IGN;
                end
              end
            end
          end
        end
        ST_ADDR: begin
          if (ien) begin
            sh_nxt = shin(sh_r, al, din);
            cnt_nxt = cnt_r + 6'(al);
            if (cnt_nxt == alen) begin
              addr_nxt = (alen == ABITS4) ? sh_nxt : {ext_addr, sh_nxt[23:0]};
              cv_nxt = 1'b1;
              cnt_nxt = '0;
              sh_nxt = '0;
              if (inf_r.dmy != 4'h0) begin
                st_nxt = ST_DMY;
              end else if (inf_r.rd) begin
                st_nxt = ST_RDAT;
                load = 1'b1;
              end else begin
                st_nxt = inf_r.wr ? ST_WDAT : ST_IGN;
              end
            end
          end
        end
        ST_DMY: begin
          if (ien) begin
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_nxt == {2'h0, inf_r.dmy}) begin
              st_nxt = ST_RDAT;
              load = 1'b1;
            end
          end
        end
        ST_RDAT: begin
          if (oen) begin
            dout_nxt = topb(tx_r, dl);
            tx_nxt = tx_r << dl;
            txc_nxt = txc_r + 4'(dl);
            drv_nxt = 1'b1;
            load = (txc_nxt == TX_BITS);
          end
        end
        ST_WDAT: begin
          if (ien) begin
            sh_nxt = shin(sh_r, dl, din);
            cnt_nxt = cnt_r + 6'(dl);
            if (cnt_nxt == BYTE_BITS) begin
              cnt_nxt = '0;
              // A full FIFO stalls the push; a second byte then is lost
              if (push_r && !fifo_rdy) begin
                ovf_nxt = 1'b1;
              end else begin
                push_nxt = 1'b1;
                pd_nxt = sh_nxt[7:0];
              end
            end
          end
        end
        ST_IGN: st_nxt = ST_IGN;
        default: st_nxt = ST_IDLE;
      endcase
      if (load) begin
        tx_nxt = inf_nxt.st ? stat : tx_byte;
        take_nxt = ~inf_nxt.st;
        txc_nxt = '0;
      end
      if (st_nxt == ST_RDAT && drv_nxt && !pz_nxt) begin
        oe_nxt = oem(dl);
      end
    end
    bf_nxt = (bsy_nxt != '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      inf_r <= '0;
      sh_r <= '0;
      cnt_r <= '0;
      cmd_r <= '0;
      addr_r <= '0;
      tx_r <= '0;
      txc_r <= '0;
      dout_r <= '0;
      oe_r <= '0;
      pd_r <= '0;
      drv_r <= 1'b0;
      ok_r <= 1'b0;
      qpi_r <= QPI_RST;
      a4_r <= A4_RST;
      ren_r <= 1'b0;
      arm_r <= 1'b0;
      pz_r <= 1'b0;
      init_r <= 1'b0;
      cv_r <= 1'b0;
      take_r <= 1'b0;
      end_r <= 1'b0;
      push_r <= 1'b0;
      ovf_r <= 1'b0;
      bsy_r <= '0;
      bf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      inf_r <= inf_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      tx_r <= tx_nxt;
      txc_r <= txc_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      pd_r <= pd_nxt;
      drv_r <= drv_nxt;
      ok_r <= ok_nxt;
      qpi_r <= qpi_nxt;
      a4_r <= a4_nxt;
      ren_r <= ren_nxt;
      arm_r <= arm_nxt;
      pz_r <= pz_nxt;
      init_r <= init_nxt;
      cv_r <= cv_nxt;
      take_r <= take_nxt;
      end_r <= end_nxt;
      push_r <= push_nxt;
      ovf_r <= ovf_nxt;
      bsy_r <= bsy_nxt;
      bf_r <= bf_nxt;
    end
  end

  sfhi_fifo #(.W(FIFO_WD), .D(FIFO_DP)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(fifo_rdy),
    .in_data(pd_r),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

  assign data_line_out = dout_r;
  assign data_line_oe = oe_r;
  assign tx_take = take_r;
  assign cmd = cmd_r;
  assign addr = addr_r;
  assign cmd_valid = cv_r;
  assign cmd_end = end_r;
  assign wr_overrun = ovf_r;
  assign four_line_instruction_mode = qpi_r;
  assign current_address_width = a4_r;
  assign paused = pz_r;
  assign busy = bf_r;

  // *********************************************************
  // Checks
  // *********************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  cs_float_a: assert property (cs_hi |=> oe_r == 4'h0)
    else $error("Lines driven while deselected");
  pause_float_a: assert property (pz_r |-> oe_r == 4'h0)
    else $error("Lines driven while paused");
  qpi_entry_a: assert property ($rose(qpi_r) |-> $past(quad_enable))
    else $error("Four-line mode entered without quad enable");
  quad_gate_a: assert property ($rose(st_r == ST_ADDR) && inf_r.qd |-> $past(quad_enable))
    else $error("Quad instruction run without quad enable");
  dout_edge_a: assert property ($changed(dout_r) |-> $past(fall || (rise && inf_r.dtr)))
    else $error("Output changed off its clock edge");
  soft_reset_a: assert property ($rose(bf_r) |-> !qpi_r && $past(ren_r, 2))
    else $error("Software reset without enable or left four-line mode");
  busy_block_a: assert property (bsy && cs_fall |=> st_r == ST_IGN)
    else $error("Command taken during reset recovery");
  a4_switch_a: assert property (cs_rise && ok_r && cmd_r == OP_A4_ON |=> a4_r)
    else $error("Enter 4-byte did not switch width");
  ext_addr_a: assert property (cv_r && inf_r.adr && !a4_r && !inf_r.f4
                               |-> addr_r[31:24] == $past(ext_addr))
    else $error("3-byte address lacks extended byte");
  hold_gate_a: assert property (quad_enable |=> !pz_r)
    else $error("Pause active with quad enable set");
  pause_start_a: assert property (!pz_r && hold_ok && !cs_hi && !sck && !din[3]
                                  |=> pz_r)
    else $error("Pause did not start with clock low");
endmodule : sfhi_core

// ===== bench/sfhi_host.sv
// Behavioural SPI host model that drives the serial pins in clock mode 0, or in mode 3 through idle
`timescale 1ns/100ps
module sfhi_host (
  input wire logic clk_sys, // Bench clock
  input wire logic [3:0] pin_lvl, // Resolved line levels
  output logic sclk, // Serial clock
  output logic cs_n, // Chip select
  output logic [3:0] dl // Host line drive
);
  // ****************
  // Pin sequencing
  // ****************
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dl = 4'hF;
  end
  // Six system clocks a half period, above the three the synchroniser needs
  task automatic half();
    repeat (6) @(posedge clk_sys);
    #2;
  endtask : half
  task automatic sel();
    cs_n = 1'b0;
    half();
  endtask : sel
  // Released lines show the inverse, so a stale value cannot pass
  task automatic desel();
    half();
    cs_n = 1'b1;
    dl[1:0] = ~dl[1:0];
    repeat (3) half();
  endtask : desel
  task automatic pin3(input logic v);
    dl[3] = v;
    repeat (2) half();
  endtask : pin3
  task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] r);
    for (int i = 8 - n; i >= 0; i -= n) begin
      if (n == 4) dl = b[i +: 4];
      else if (n == 2) dl[1:0] = b[i +: 2];
      else dl[0] = b[i];
      half();
      sclk = 1'b1;
      r = (n == 1) ? {r[6:0], pin_lvl[1]} : ((r << n) | 8'(pin_lvl & 4'((1 << n) - 1)));
      half();
      sclk = 1'b0;
    end
  endtask : xfer
  // Double-rate bits change a quarter period off both clock edges
  task automatic ddr(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      dl[0] = b[i];
      repeat (3) @(posedge clk_sys);
      #2;
      r = {r[6:0], pin_lvl[1]};
      sclk = ~sclk;
      repeat (3) @(posedge clk_sys);
      #2;
    end
  endtask : ddr
  task automatic idle(input logic v);
    sclk = v;
    half();
  endtask : idle
endmodule : sfhi_host

// ===== bench/tb.sv
// Self-checking bench of the serial flash front end
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import sfhi_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, quad_enable = 1'b0, powerup_address_width = 1'b0;
  logic wr_ready = 1'b0, drain = 1'b0, sclk, cs_n, tx_take, cmd_valid, cmd_end, wr_valid;
  logic wr_overrun, four_line_instruction_mode, current_address_width, paused, busy;
  logic [3:0] host_dl, dli, data_line_out, data_line_oe;
  logic [7:0] ext_addr, tx_byte, cmd, wr_data, got_cmd, r, b;
  logic [31:0] addr, got_addr, da;
  logic [7:0] wq[$];
  int failures = 0, num_checks = 0, cycles = 0, takes = 0, ends = 0, e0 = 0;
  integer seed = 32'h1fcedd9c;
  always #12.5 clk_sys = ~clk_sys;
  // Wire level: the core wins each line whose data_line_oe bit is set, the host drives the rest
  assign dli = (data_line_oe & data_line_out) | (~data_line_oe & host_dl);
  sfhi_host host_i (.clk_sys(clk_sys), .pin_lvl(dli), .sclk(sclk), .cs_n(cs_n), .dl(host_dl));
  sfhi_core sfhi_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .serial_clock(sclk),
    .chip_select_n(cs_n), .data_line_in(dli), .data_line_out(data_line_out),
    .data_line_oe(data_line_oe), .quad_enable(quad_enable),
    .powerup_address_width(powerup_address_width), .ext_addr(ext_addr), .tx_byte(tx_byte),
    .tx_take(tx_take), .cmd(cmd), .addr(addr), .cmd_valid(cmd_valid), .cmd_end(cmd_end),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_overrun(wr_overrun),
    .four_line_instruction_mode(four_line_instruction_mode),
    .current_address_width(current_address_width), .paused(paused), .busy(busy));
  // ****************
  // Model and checks
  // ****************
  task automatic end_sim();
    if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      end_sim();
    end
    if (tx_take) takes++;
    if (cmd_end) ends++;
    if (cmd_valid) begin
      got_cmd = cmd;
      got_addr = addr;
    end
    if (wr_valid && wr_ready && wq.size() > 0) begin
      `CHK(wr_data, wq[0])
      void'(wq.pop_front());
    end
    wr_ready <= #2 drain & 1'($random(seed));
  end
  task automatic cmd1(input logic [7:0] op, input int n);
    host_i.sel();
    host_i.xfer(op, n, r);
    host_i.desel();
  endtask : cmd1
  task automatic rd(input logic [7:0] op, input int na, input int n, input int dmy);
    logic [31:0] a;
    int t0;
    a = $random(seed);
    t0 = takes;
    host_i.sel();
    host_i.xfer(op, 1, r);
    for (int i = na - 1; i >= 0; i--) host_i.xfer(a[8*i +: 8], (op == OP_DIOR) ? 2 : 1, r);
    for (int i = 0; i < dmy; i++) host_i.xfer(8'h00, 1, r);
    `CHK(got_cmd, op)
    `CHK(got_addr, (na == 4) ? a : {ext_addr, a[23:0]})
    host_i.xfer(8'hFF, n, r);
    `CHK(r, tx_byte)
    `CHK(takes - t0, 2)
  endtask : rd
  initial begin
    ext_addr = 8'($random(seed));
    tx_byte = 8'($random(seed));
    repeat (6) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    `CHK(current_address_width, 1'b0)
    `CHK(four_line_instruction_mode, 1'b0)
    rd(OP_RD, 3, 1, 0);
    `CHK(data_line_oe, 4'h2)
    host_i.pin3(1'b0);
    `CHK(paused, 1'b1)
    `CHK(data_line_oe, 4'h0)
    host_i.pin3(1'b1);
    `CHK(paused, 1'b0)
    host_i.xfer(8'hFF, 1, r);
    `CHK(r, tx_byte)
    host_i.desel();
    `CHK(data_line_oe, 4'h0)
    rd(OP_RD4, 4, 1, 0);
    host_i.desel();
    rd(OP_DOR, 3, 2, 1);
    `CHK(data_line_oe, 4'h3)
    host_i.desel();
    da = $random(seed);
    host_i.sel();
    host_i.xfer(OP_DTRRD, 1, r);
    for (int i = 2; i >= 0; i--) host_i.ddr(da[8*i +: 8], r);
    host_i.xfer(8'h00, 1, r);
    `CHK(got_cmd, OP_DTRRD)
    `CHK(got_addr, {ext_addr, da[23:0]})
    host_i.half();
    host_i.ddr(8'hFF, r);
    `CHK(r, tx_byte)
    host_i.desel();
    e0 = ends;
    host_i.idle(1'b1);
    host_i.sel();
    host_i.idle(1'b0);
    host_i.xfer(OP_A4_ON, 1, r);
    host_i.idle(1'b1);
    host_i.desel();
    host_i.idle(1'b0);
    `CHK(ends, e0 + 1)
    `CHK(current_address_width, 1'b1)
    host_i.sel();
    host_i.xfer(OP_RDSR3, 1, r);
    host_i.xfer(8'hFF, 1, r);
    host_i.desel();
    `CHK(r[SR_ADS], 1'b1)
    rd(OP_RD, 4, 1, 0);
    host_i.desel();
    cmd1(OP_A4_OFF, 1);
    `CHK(current_address_width, 1'b0)
    host_i.sel();
    host_i.xfer(OP_PP, 1, r);
    for (int i = 0; i < 43; i++) begin
      b = 8'($random(seed));
      // Buffer words, its output register and one held push survive
      if (i >= 3 && i < 37) wq.push_back(b);
      host_i.xfer(b, 1, r);
    end
    host_i.desel();
    `CHK(wr_overrun, 1'b1)
    drain = 1'b1;
    for (int i = 0; i < 800 && wq.size() > 0; i++) @(posedge clk_sys);
    #2 drain = 1'b0;
    `CHK(wq.size(), 0)
    `CHK(wr_valid, 1'b0)
    cmd1(OP_QPI_ON, 1);
    `CHK(four_line_instruction_mode, 1'b0)
    `CHK(wr_overrun, 1'b0)
    host_i.sel();
    host_i.xfer(OP_QOR, 1, r);
    host_i.desel();
    `CHK(got_cmd, OP_QPI_ON)
    quad_enable = 1'b1;
    rd(OP_QOR, 3, 4, 1);
    `CHK(data_line_oe, 4'hF)
    host_i.desel();
    host_i.sel();
    host_i.pin3(1'b0);
    `CHK(paused, 1'b0)
    host_i.pin3(1'b1);
    host_i.desel();
    cmd1(OP_QPI_ON, 1);
    `CHK(four_line_instruction_mode, 1'b1)
    cmd1(OP_QPI_OFF, 4);
    `CHK(four_line_instruction_mode, 1'b0)
    cmd1(OP_QPI_ON, 1);
    powerup_address_width = 1'b1;
    cmd1(OP_RSTEN, 4);
    cmd1(OP_RST, 4);
    `CHK(busy, 1'b1)
    `CHK(four_line_instruction_mode, 1'b0)
    `CHK(current_address_width, 1'b1)
    e0 = ends;
    cmd1(OP_A4_OFF, 1);
    `CHK(current_address_width, 1'b1)
    `CHK(ends, e0)
    for (int i = 0; i < 1300 && busy === 1'b1; i++) @(posedge clk_sys);
    #2;
    `CHK(busy, 1'b0)
    end_sim();
  end
endmodule : tb
